/* dspi_top.sv */
// Dual serial port PWM generator with eight general pins.
// Assumes all pins arrive unsynchronised; one 250 MHz clock drives all logic.
//
// Function
// - Only low three address bits select registers
// - Writes ignored while PWM runs
// - Identification register read-only fixed byte
// - Control bit 0 starts PWM; writes cannot clear it while running
// - Control bit 7 reads aux AND select
// - External start pin also runs PWM
// - Output high for 16-bit on-time ticks
// - 16-bit period sets cycle length
// - Direction bit one means output
// - Level reads pins, write drives outputs
// - One shared register set, one owner
// - Simultaneous writes: sampled port dropped; clocked port wins only as owner
// - First port also oversampled; shifts on detected host clock rises
// - Clocked port reads use 24-bit frames
// - Second port oversampled, up to 25 MHz
// - Sampled port reads use 16-bit frames
// - On-time resets to 0x14 and 0x82
// - Period resets 0x50, 0xC3; others zero
`timescale 1ns/1ps
`default_nettype none
module dspi_top
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // Dedicated pins
   input wire logic [7:0] DEDICATED_INPUTS,
   input wire logic ENA,
   output logic [7:0] DEDICATED_OUTPUTS,
   // General pins
   input wire logic [7:0] IO_IN,
   output logic [7:0] IO_OUT,
   output logic [7:0] IO_OE
);
   import dspi_pkg::*;

   // ********************************
   // Declarations
   // ********************************
   logic [7:0] ctrl_reg; // PWM control, only bit 0 stored
   logic [7:0] on_lo_reg; // On-time low byte
   logic [7:0] on_hi_reg; // On-time high byte
   logic [7:0] per_lo_reg; // Period low byte
   logic [7:0] per_hi_reg; // Period high byte
   logic [7:0] dir_reg; // Pin direction
   logic [7:0] level_reg; // Pin output levels
   logic [2:0] pin1_reg; // First stage: aux, start, enable
   logic [2:0] pin2_reg; // Second stage
   logic [7:0] io1_reg; // First stage of general inputs
   logic [7:0] io2_reg; // Second stage of general inputs
   dspi_owner_t owner_reg; // Port holding the registers
   dspi_owner_t owner_next;
   logic run; // PWM generation active
   logic aux_and; // Aux pin AND design select
   logic pwm_wave; // Waveform from generator
   logic act_clk; // Clocked port selected
   logic act_smp; // Sampled port selected
   logic wr_clk; // Write strobe, clocked port
   logic wr_smp; // Write strobe, sampled port
   logic [2:0] wa_clk;
   logic [2:0] wa_smp;
   logic [7:0] wd_clk;
   logic [7:0] wd_smp;
   logic [2:0] ra_clk;
   logic [2:0] ra_smp;
   logic [7:0] rd_clk;
   logic [7:0] rd_smp;
   logic miso_clk;
   logic miso_smp;
   logic commit_clk; // Clocked port write accepted
   logic commit_smp; // Sampled port write accepted
   logic commit; // Any write accepted
   logic [2:0] wa; // Accepted write address
   logic [7:0] wd; // Accepted write data

   // ********************************
   // Pin synchronisers
   // ********************************
   // Two stages for every pin read by logic
   always_ff @(posedge CLOCK)
   begin
      pin1_reg <= {DEDICATED_INPUTS[7], DEDICATED_INPUTS[6], ENA};
      pin2_reg <= pin1_reg;
      io1_reg <= IO_IN;
      io2_reg <= io1_reg;
   end

   assign aux_and = pin2_reg[2] && pin2_reg[0];
   // Register bit or external start pin runs the generator
   assign run = ctrl_reg[DSPI_CTRL_RUN_BIT] || pin2_reg[1];

   // ********************************
   // Serial ports
   // ********************************
   // Port on pins 0..2, follows the host clock edges
   dspi_serial #(
      .RD_START(DSPI_RD_START_CLK),
      .RD_BITS(DSPI_RD_BITS_CLK)
   ) u_port_clk (
      .CLOCK(CLOCK),
      .RESET(RESET),
      .sclk_pin(DEDICATED_INPUTS[0]),
      .cs_n_pin(DEDICATED_INPUTS[2]),
      .mosi_pin(DEDICATED_INPUTS[1]),
      .miso(miso_clk),
      .rd_data(rd_clk),
      .rd_addr(ra_clk),
      .wr_pulse(wr_clk),
      .wr_addr(wa_clk),
      .wr_data(wd_clk),
      .active(act_clk)
   );

   // Port on pins 3..5, oversampled by the system clock
   dspi_serial #(
      .RD_START(DSPI_RD_START_SMP),
      .RD_BITS(DSPI_RD_BITS_SMP)
   ) u_port_smp (
      .CLOCK(CLOCK),
      .RESET(RESET),
      .sclk_pin(DEDICATED_INPUTS[3]),
      .cs_n_pin(DEDICATED_INPUTS[5]),
      .mosi_pin(DEDICATED_INPUTS[4]),
      .miso(miso_smp),
      .rd_data(rd_smp),
      .rd_addr(ra_smp),
      .wr_pulse(wr_smp),
      .wr_addr(wa_smp),
      .wr_data(wd_smp),
      .active(act_smp)
   );

   // ********************************
   // Ownership arbiter
   // ********************************
   // First selected port owns the registers until it deselects
   always_comb
   begin
      owner_next = owner_reg;
      case (owner_reg)
         OWN_NONE:
         begin
            if (act_clk)
            begin
               owner_next = OWN_CLK; // Clocked port has priority
            end
            else if (act_smp)
            begin
               owner_next = OWN_SMP;
            end
         end
         OWN_CLK:
         begin
            if (!act_clk)
            begin
               owner_next = OWN_NONE;
            end
         end
         OWN_SMP:
         begin
            if (!act_smp)
            begin
               owner_next = OWN_NONE;
            end
         end
         default:
         begin
            owner_next = OWN_NONE;
         end
      endcase
   end

   // Owner state
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         owner_reg <= OWN_NONE;
      end
      else
      begin
         owner_reg <= owner_next;
      end
   end

   // Only the owner writes; a clocked strobe blocks a sampled write; frozen while running
   assign commit_clk = wr_clk && owner_reg == OWN_CLK && !run;
   assign commit_smp = wr_smp && owner_reg == OWN_SMP && !wr_clk && !run;
   assign commit = commit_clk || commit_smp;
   assign wa = commit_clk ? wa_clk : wa_smp;
   assign wd = commit_clk ? wd_clk : wd_smp;

   // ********************************
   // Register file
   // ********************************
   // Read value of one register
   function automatic logic [7:0] reg_value(input logic [2:0] addr);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         DSPI_ADDR_IDENT: v = DSPI_IDENT_VALUE;
         DSPI_ADDR_CTRL: v = {aux_and, 6'h00, ctrl_reg[DSPI_CTRL_RUN_BIT]};
         DSPI_ADDR_ON_LO: v = on_lo_reg;
         DSPI_ADDR_ON_HI: v = on_hi_reg;
         DSPI_ADDR_PER_LO: v = per_lo_reg;
         DSPI_ADDR_PER_HI: v = per_hi_reg;
         DSPI_ADDR_DIR: v = dir_reg;
         DSPI_ADDR_LEVEL: v = io2_reg;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // A port without the grant reads zero
   // Kept in a process so that register changes seen inside the function wake it
   always_comb
   begin
      rd_clk = (owner_reg == OWN_CLK) ? reg_value(ra_clk) : 8'h00;
      rd_smp = (owner_reg == OWN_SMP) ? reg_value(ra_smp) : 8'h00;
   end

   // Write decode; the identification offset has no storage
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         ctrl_reg <= DSPI_RST_CTRL;
         on_lo_reg <= DSPI_RST_ON_LO;
         on_hi_reg <= DSPI_RST_ON_HI;
         per_lo_reg <= DSPI_RST_PER_LO;
         per_hi_reg <= DSPI_RST_PER_HI;
         dir_reg <= DSPI_RST_DIR;
         level_reg <= DSPI_RST_LEVEL;
      end
      else if (commit)
      begin
         case (wa)
            DSPI_ADDR_CTRL: ctrl_reg <= {7'h00, wd[DSPI_CTRL_RUN_BIT]};
            DSPI_ADDR_ON_LO: on_lo_reg <= wd;
            DSPI_ADDR_ON_HI: on_hi_reg <= wd;
            DSPI_ADDR_PER_LO: per_lo_reg <= wd;
            DSPI_ADDR_PER_HI: per_hi_reg <= wd;
            DSPI_ADDR_DIR: dir_reg <= wd;
            DSPI_ADDR_LEVEL: level_reg <= wd;
            default:
            begin
               ctrl_reg <= ctrl_reg; // Identification write ignored
            end
         endcase
      end
   end

   // ********************************
   // PWM generator
   // ********************************
   dspi_pwm u_pwm (
      .CLOCK(CLOCK),
      .RESET(RESET),
      .run(run),
      .on_time({on_hi_reg, on_lo_reg}),
      .period({per_hi_reg, per_lo_reg}),
      .pwm(pwm_wave)
   );

   // ********************************
   // Outputs
   // ********************************
   // Registered pin drive; spare dedicated outputs stay low
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         DEDICATED_OUTPUTS <= 8'h00;
      end
      else
      begin
         DEDICATED_OUTPUTS <= {5'h00, pwm_wave, miso_smp, miso_clk};
      end
   end

   assign IO_OUT = level_reg;
   assign IO_OE = dir_reg;

   // ********************************
   // Checks
   // ********************************
   chk_frozen_while_run: assert property (@(posedge CLOCK) disable iff (RESET)
      run |=> $stable({on_lo_reg, on_hi_reg, per_lo_reg, per_hi_reg, dir_reg, level_reg}))
      else $error("register changed while PWM ran");
   chk_ident_fixed: assert property (@(posedge CLOCK) disable iff (RESET)
      (owner_reg == OWN_CLK && ra_clk == DSPI_ADDR_IDENT) |-> (rd_clk == DSPI_IDENT_VALUE))
      else $error("identification read wrong");
   chk_ctrl_aux_bit: assert property (@(posedge CLOCK) disable iff (RESET)
      (owner_reg == OWN_SMP && ra_smp == DSPI_ADDR_CTRL) |-> (rd_smp[7] == aux_and))
      else $error("control bit 7 mismatch");
   chk_single_grant: assert property (@(posedge CLOCK) disable iff (RESET)
      !(commit_clk && commit_smp))
      else $error("two ports committed at once");
   chk_clk_port_wins: assert property (@(posedge CLOCK) disable iff (RESET)
      (wr_clk && wr_smp) |-> !commit_smp)
      else $error("sampled port beat clocked port");
   chk_dir_to_enable: assert property (@(posedge CLOCK) disable iff (RESET)
      (commit && wa == DSPI_ADDR_DIR) |=> (IO_OE == $past(wd)))
      else $error("direction write not on enables");
   chk_reset_defaults: assert property (@(posedge CLOCK)
      $past(RESET) |-> ({on_hi_reg, on_lo_reg, per_hi_reg, per_lo_reg} == 32'h8214_C350))
      else $error("timing registers wrong after reset");
   chk_spare_low: assert property (@(posedge CLOCK) disable iff (RESET)
      $past(RESET) || DEDICATED_OUTPUTS[7:3] == 5'h00)
      else $error("spare outputs driven high");

endmodule
`default_nettype wire

/* dspi_pkg.sv */
// Shared constants for the dual serial PWM and pin controller.
// Assumes a single 250 MHz system clock and byte-wide registers.
package dspi_pkg;

   // ********************************
   // Register map
   // ********************************
   localparam logic [2:0] DSPI_ADDR_IDENT = 3'h0; // Identification
   localparam logic [2:0] DSPI_ADDR_CTRL = 3'h1; // PWM control
   localparam logic [2:0] DSPI_ADDR_ON_LO = 3'h2; // On-time low byte
   localparam logic [2:0] DSPI_ADDR_ON_HI = 3'h3; // On-time high byte
   localparam logic [2:0] DSPI_ADDR_PER_LO = 3'h4; // Period low byte
   localparam logic [2:0] DSPI_ADDR_PER_HI = 3'h5; // Period high byte
   localparam logic [2:0] DSPI_ADDR_DIR = 3'h6; // Pin direction
   localparam logic [2:0] DSPI_ADDR_LEVEL = 3'h7; // Pin level

   // ********************************
   // Values after reset
   // ********************************
   localparam logic [7:0] DSPI_IDENT_VALUE = 8'h5A; // Arbitrary identity value
   localparam logic [7:0] DSPI_RST_CTRL = 8'h00;
   localparam logic [7:0] DSPI_RST_ON_LO = 8'h14;
   localparam logic [7:0] DSPI_RST_ON_HI = 8'h82;
   localparam logic [7:0] DSPI_RST_PER_LO = 8'h50;
   localparam logic [7:0] DSPI_RST_PER_HI = 8'hC3;
   localparam logic [7:0] DSPI_RST_DIR = 8'h00;
   localparam logic [7:0] DSPI_RST_LEVEL = 8'h00;

   // ********************************
   // Field positions and frame layout
   // ********************************
   localparam int DSPI_CTRL_RUN_BIT = 0; // PWM enable
   localparam int DSPI_CTRL_AUX_BIT = 7; // Auxiliary AND select
   localparam int DSPI_WR_BITS = 16; // Write frame length
   localparam int DSPI_HDR_BITS = 8; // Header byte length
   localparam int DSPI_RD_START_CLK = 16; // Data phase start, clocked port
   localparam int DSPI_RD_BITS_CLK = 24; // Read frame, clocked port
   localparam int DSPI_RD_START_SMP = 8; // Data phase start, sampled port
   localparam int DSPI_RD_BITS_SMP = 16; // Read frame, sampled port

   // Which serial port currently holds the register set
   typedef enum logic [1:0] {OWN_NONE, OWN_CLK, OWN_SMP} dspi_owner_t;

endpackage

/* dspi_pwm.sv */
// PWM tick counter and output stage.
// Assumes run, on-time and period come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module dspi_pwm
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // Settings
   input wire logic run,
   input wire logic [15:0] on_time,
   input wire logic [15:0] period,
   // Waveform
   output logic pwm
);
   import dspi_pkg::*;

   logic [15:0] cnt_reg; // Ticks into current cycle
   logic wrap; // Last tick of a cycle

   // ********************************
   // Counter
   // ********************************
   // Wrap once the next tick would reach the period
   assign wrap = ({1'b0, cnt_reg} + 17'h0_0001) >= {1'b0, period};

   // Count ticks while running, rest at zero otherwise
   always_ff @(posedge CLOCK)
   begin
      if (RESET || !run)
      begin
         cnt_reg <= '0;
      end
      else if (wrap)
      begin
         cnt_reg <= '0;
      end
      else
      begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // High while the count is below the on-time
   always_ff @(posedge CLOCK)
   begin
      if (RESET || !run)
      begin
         pwm <= 1'b0;
      end
      else
      begin
         pwm <= (cnt_reg < on_time);
      end
   end

   // ********************************
   // Checks
   // ********************************
   chk_pwm_high_phase: assert property (@(posedge CLOCK) disable iff (RESET)
      (run && cnt_reg < on_time) |=> pwm)
      else $error("pwm low during on-time");
   chk_pwm_cycle_wrap: assert property (@(posedge CLOCK) disable iff (RESET)
      (run && wrap) |=> (cnt_reg == 16'h0000))
      else $error("counter failed to wrap at period");
   chk_pwm_stopped: assert property (@(posedge CLOCK) disable iff (RESET)
      (!run) [*2] |-> (!pwm && cnt_reg == 16'h0000))
      else $error("pwm active while stopped");

endmodule
`default_nettype wire

/* dspi_serial.sv */
// Serial register port that oversamples clock, select and data pins.
// Assumes select is active low and data changes on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module dspi_serial
#(
   parameter int RD_START = 8,
   parameter int RD_BITS = 16
)
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // Serial pins
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic mosi_pin,
   output logic miso,
   // Register access
   input wire logic [7:0] rd_data,
   output logic [2:0] rd_addr,
   output logic wr_pulse,
   output logic [2:0] wr_addr,
   output logic [7:0] wr_data,
   output logic active
);
   import dspi_pkg::*;

   logic [2:0] sync1_reg; // First synchroniser stage
   logic [2:0] sync2_reg; // Second synchroniser stage
   logic sclk_d_reg; // Previous serial clock level
   logic [14:0] shift_reg; // Received bits
   logic [4:0] cnt_reg; // Bits received in frame
   logic rw_reg; // Frame is a read
   logic [7:0] out_reg; // Read byte being sent
   logic rise;
   logic fall;

   // ********************************
   // Pin synchronisers and edges
   // ********************************
   always_ff @(posedge CLOCK)
   begin
      sync1_reg <= {sclk_pin, cs_n_pin, mosi_pin};
      sync2_reg <= sync1_reg;
      sclk_d_reg <= sync2_reg[2];
   end

   assign active = !sync2_reg[1];
   assign rise = active && sync2_reg[2] && !sclk_d_reg;
   assign fall = active && !sync2_reg[2] && sclk_d_reg;

   // ********************************
   // Receive
   // ********************************
   // Shift in on rising edges, drop the frame when deselected
   always_ff @(posedge CLOCK)
   begin
      if (RESET || !active)
      begin
         shift_reg <= '0;
         cnt_reg <= '0;
      end
      else if (rise)
      begin
         shift_reg <= {shift_reg[13:0], sync2_reg[0]};
         cnt_reg <= (cnt_reg == 5'h1F) ? cnt_reg : cnt_reg + 5'h01;
      end
   end

   // Header byte gives direction and the low three address bits
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         rw_reg <= 1'b0;
         rd_addr <= '0;
      end
      else if (rise && cnt_reg == 5'(DSPI_HDR_BITS - 1))
      begin
         rw_reg <= shift_reg[6];
         rd_addr <= {shift_reg[1:0], sync2_reg[0]};
      end
   end

   // Sixteenth bit of a write frame commits the byte
   always_ff @(posedge CLOCK)
   begin
      wr_pulse <= 1'b0;
      if (RESET)
      begin
         wr_addr <= '0;
         wr_data <= '0;
      end
      else if (rise && cnt_reg == 5'(DSPI_WR_BITS - 1) && !shift_reg[14])
      begin
         wr_pulse <= 1'b1;
         wr_addr <= shift_reg[9:7];
         wr_data <= {shift_reg[6:0], sync2_reg[0]};
      end
   end

   // ********************************
   // Transmit
   // ********************************
   // Present the read byte on falling edges of the data phase
   always_ff @(posedge CLOCK)
   begin
      if (RESET || !active)
      begin
         miso <= 1'b0;
         out_reg <= '0;
      end
      else if (fall && rw_reg && cnt_reg == 5'(RD_START))
      begin
         miso <= rd_data[7];
         out_reg <= {rd_data[6:0], 1'b0};
      end
      else if (fall && rw_reg && cnt_reg > 5'(RD_START) && cnt_reg < 5'(RD_BITS))
      begin
         miso <= out_reg[7];
         out_reg <= {out_reg[6:0], 1'b0};
      end
   end

   chk_desel_no_write: assert property (@(posedge CLOCK) disable iff (RESET)
      (!active) [*2] |=> !wr_pulse)
      else $error("write committed while deselected");

endmodule
`default_nettype wire

/* dspi_host.sv */
// Serial host model that drives both register ports of the PWM block.
// Assumes mode 0 framing, active-low select and a 125 ns serial clock.
`timescale 1ns/1ps
`default_nettype none
module dspi_host
(
   // Serial pins toward the device: index 0 clocked port, 1 sampled port
   output logic [1:0] sclk,
   output logic [1:0] mosi,
   output logic [1:0] cs_n,
   // Data returned by the device
   input wire logic [1:0] miso
);

   // ************************************
   // Idle levels
   // ************************************
   // Clock stands low between frames, selects stay high
   initial
   begin
      sclk = 2'b00;
      mosi = 2'b00;
      cs_n = 2'b11;
   end

   // ************************************
   // Frame engine
   // ************************************
   // Shifts n bits MSB first and captures the return line on each rise
   task automatic xfer(input int p, input int n, input logic [23:0] tx, output logic [23:0] rx);
      rx = '0;
      // Small offset keeps serial edges away from system clock edges
      #0.3;
      cs_n[p] = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi[p] = tx[i];
         #62.5;
         sclk[p] = 1'b1;
         rx = {rx[22:0], miso[p]};
         #62.5;
         sclk[p] = 1'b0;
      end
      cs_n[p] = 1'b1;
      // Released line shows the inverse of its last bit
      mosi[p] = ~mosi[p];
      #100;
   endtask

endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the dual serial PWM and pin controller.
// Assumes the host model above and the register map of the shared package.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dspi_pkg::*;

   // ************************************
   // Signals
   // ************************************
   logic clock; // System clock
   logic reset; // Synchronous reset
   logic ena; // Design-selected level
   logic aux; // Auxiliary input
   logic start; // External PWM start
   logic [7:0] io_in; // General pin levels
   logic [7:0] dout; // Dedicated outputs
   logic [7:0] io_out; // General pin outputs
   logic [7:0] io_oe; // General pin enables
   logic [1:0] sclk; // Serial clocks
   logic [1:0] mosi; // Serial data to device
   logic [1:0] cs_n; // Serial selects
   logic [7:0] h; // PWM high count
   int fail_count = 0; // Mismatches seen
   int checked = 0; // Comparisons made
   localparam logic [7:0] RST_TAB [8] = '{DSPI_IDENT_VALUE, DSPI_RST_CTRL, DSPI_RST_ON_LO, DSPI_RST_ON_HI,
      DSPI_RST_PER_LO, DSPI_RST_PER_HI, DSPI_RST_DIR, DSPI_RST_LEVEL};

   // ************************************
   // Clock and instances
   // ************************************
   // Free-running 250 MHz clock
   always #2 clock = ~clock;

   dspi_top dut
   (
      .CLOCK(clock),
      .RESET(reset),
      .DEDICATED_INPUTS({aux, start, cs_n[1], mosi[1], sclk[1], cs_n[0], mosi[0], sclk[0]}),
      .ENA(ena),
      .DEDICATED_OUTPUTS(dout),
      .IO_IN(io_in),
      .IO_OUT(io_out),
      .IO_OE(io_oe)
   );

   dspi_host host
   (
      .sclk(sclk),
      .mosi(mosi),
      .cs_n(cs_n),
      .miso(dout[1:0])
   );

   // ************************************
   // Tasks
   // ************************************
   // Compares one byte and counts it
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask

   // Write frame on port p; hi fills the ignored bits
   task automatic wr(input int p, input logic [3:0] hi, input logic [2:0] a, input logic [7:0] d);
      logic [23:0] rx;
      @(negedge clock);
      host.xfer(p, DSPI_WR_BITS, {8'h00, 1'b0, hi, a, d}, rx);
   endtask

   // Read frame on port p and compare the returned byte
   task automatic rchk(input int p, input logic [2:0] a, input logic [7:0] exp, input string what);
      logic [23:0] rx;
      @(negedge clock);
      if (p == 0)
         host.xfer(0, DSPI_RD_BITS_CLK, {1'b1, 4'h0, a, 16'h0000}, rx);
      else
         host.xfer(1, DSPI_RD_BITS_SMP, {8'h00, 1'b1, 4'h0, a, 8'h00}, rx);
      check(what, rx[7:0], exp);
   endtask

   // Counts PWM high cycles over n settled samples
   task automatic pwm_highs(input int n);
      h = 8'h00;
      repeat (n)
      begin
         @(negedge clock);
         h = h + {7'h00, dout[2]};
      end
   endtask

   // Holds reset long enough to flush the synchronisers
   task automatic do_reset();
      @(negedge clock);
      reset = 1'b1;
      repeat (2) @(negedge clock);
      check("pwm_in_reset", {7'h00, dout[2]}, 8'h00);
      reset = 1'b0;
      repeat (4) @(negedge clock);
   endtask

   // Prints the counts and the verdict, then stops
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ************************************
   // Watchdog
   // ************************************
   // Cuts a hang short well after the tests should have ended
   initial
   begin
      #300000;
      fail_count++;
      close_out();
   end

   // ************************************
   // Test sequence
   // ************************************
   initial
   begin
      clock = 1'b0;
      reset = 1'b1;
      ena = 1'b1;
      aux = 1'b0;
      start = 1'b0;
      io_in = 8'h00;
      do_reset();
      // Reset values through the sampled port
      for (int a = 0; a < 8; a++)
         rchk(1, 3'(a), RST_TAB[a], "reset_value");
      rchk(0, DSPI_ADDR_IDENT, DSPI_IDENT_VALUE, "ident_clocked");
      // Identification ignores writes
      wr(1, 4'h0, DSPI_ADDR_IDENT, 8'h00);
      rchk(0, DSPI_ADDR_IDENT, DSPI_IDENT_VALUE, "ident_write");
      // Ignored header bits set, shared register set
      wr(0, 4'hF, DSPI_ADDR_ON_HI, 8'h12);
      rchk(1, DSPI_ADDR_ON_HI, 8'h12, "high_addr_bits");
      // Both ports write at once
      fork
         wr(0, 4'h0, DSPI_ADDR_PER_HI, 8'h0A);
         wr(1, 4'h0, DSPI_ADDR_PER_HI, 8'hB0);
      join
      rchk(1, DSPI_ADDR_PER_HI, 8'h0A, "collision");
      // General pins
      wr(1, 4'h0, DSPI_ADDR_DIR, 8'hA5);
      wr(0, 4'h0, DSPI_ADDR_LEVEL, 8'h3C);
      @(negedge clock);
      io_in = 8'h6B;
      check("pin_enable", io_oe, 8'hA5);
      check("pin_out", io_out, 8'h3C);
      check("spare_out", {3'b000, dout[7:3]}, 8'h00);
      rchk(1, DSPI_ADDR_LEVEL, 8'h6B, "pin_in");
      // Auxiliary AND select in control bit 7
      aux = 1'b1;
      rchk(1, DSPI_ADDR_CTRL, 8'h80, "aux_and");
      @(negedge clock);
      ena = 1'b0;
      rchk(0, DSPI_ADDR_CTRL, 8'h00, "aux_no_ena");
      @(negedge clock);
      aux = 1'b0;
      ena = 1'b1;
      // On-time 3, period 8
      wr(1, 4'h0, DSPI_ADDR_ON_HI, 8'h00);
      wr(1, 4'h0, DSPI_ADDR_ON_LO, 8'h03);
      wr(0, 4'h0, DSPI_ADDR_PER_HI, 8'h00);
      wr(0, 4'h0, DSPI_ADDR_PER_LO, 8'h08);
      // Run from the start pin: 4 whole periods in 32 cycles
      @(negedge clock);
      start = 1'b1;
      repeat (20) @(negedge clock);
      pwm_highs(32);
      check("pwm_pin", h, 8'h0C);
      wr(0, 4'h0, DSPI_ADDR_ON_LO, 8'h05);
      rchk(1, DSPI_ADDR_ON_LO, 8'h03, "write_locked");
      @(negedge clock);
      start = 1'b0;
      repeat (20) @(negedge clock);
      pwm_highs(16);
      check("pwm_stopped", h, 8'h00);
      // Run from the control bit
      wr(1, 4'h0, DSPI_ADDR_CTRL, 8'h01);
      rchk(0, DSPI_ADDR_CTRL, 8'h01, "run_bit");
      pwm_highs(32);
      check("pwm_ctrl", h, 8'h0C);
      // Reset in mid-frame stops the output, restores defaults and drops the frame
      fork
         wr(0, 4'h0, DSPI_ADDR_ON_LO, 8'h77);
         begin
            repeat (200) @(negedge clock);
            do_reset();
         end
      join
      pwm_highs(16);
      check("pwm_after_reset", h, 8'h00);
      rchk(1, DSPI_ADDR_ON_LO, DSPI_RST_ON_LO, "on_lo_reset");
      rchk(0, DSPI_ADDR_CTRL, DSPI_RST_CTRL, "ctrl_reset");
      close_out();
   end

endmodule
`default_nettype wire
